// ### logic/cib_pkg.sv
// Constants, field layout and types for the compact instruction execute block
package cib_pkg;
  localparam int DATA_W = 32;
  localparam int INSTR_W = 16;
  localparam int REG_W = 4;
  localparam int CNT_W = 4;

  // Group signatures
  localparam logic [5:0] F5_SIG = 6'h11;
  localparam logic [4:0] F6_SIG = 5'h09;
  localparam logic [3:0] F7_SIG = 4'h5;
  localparam int F5_SIG_LO = 10;
  localparam int F6_SIG_LO = 11;
  localparam int F7_SIG_LO = 12;
  localparam int F7_ZERO = 9;

  // Field positions
  localparam int F5_OP_HI = 9;
  localparam int F5_OP_LO = 8;
  localparam int F5_DHI = 7;
  localparam int F5_SHI = 6;
  localparam int F_MID_HI = 5;
  localparam int F_MID_LO = 3;
  localparam int F_LOW_HI = 2;
  localparam int F_LOW_LO = 0;
  localparam int F6_RD_HI = 10;
  localparam int F6_RD_LO = 8;
  localparam int F6_IMM_HI = 7;
  localparam int F6_IMM_LO = 0;
  localparam int F7_LOAD = 11;
  localparam int F7_BYTE = 10;
  localparam int F7_RO_HI = 8;
  localparam int F7_RO_LO = 6;

  // Hi-register group operation codes
  localparam logic [1:0] HI_ADD = 2'h0;
  localparam logic [1:0] HI_CMP = 2'h1;
  localparam logic [1:0] HI_MOV = 2'h2;
  localparam logic [1:0] HI_BX = 2'h3;

  // Program counter handling
  localparam logic [REG_W-1:0] PC_REG = 4'hF;
  localparam logic [DATA_W-1:0] PC_AHEAD = 32'h00000004;
  localparam logic [DATA_W-1:0] BIT0_MASK = 32'hFFFFFFFE;
  localparam logic [DATA_W-1:0] BIT1_MASK = 32'hFFFFFFFD;
  localparam int WORD_SHIFT = 2;
  localparam int STATE_BIT = 0;
  localparam logic RESET_COMPRESSED = 1'b1;

  // Execute cycle budgets, same as the 32-bit equivalents
  localparam logic [CNT_W-1:0] CYC_ALU = 4'h1;
  localparam logic [CNT_W-1:0] CYC_PC_WRITE = 4'h3;
  localparam logic [CNT_W-1:0] CYC_BX = 4'h3;
  localparam logic [CNT_W-1:0] CYC_LOAD = 4'h3;
  localparam logic [CNT_W-1:0] CYC_STORE = 4'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_MEM = 2'b10,
    ST_HOLD = 2'b11
  } cib_state_e;
endpackage

// ### logic/cib_operand_sel.sv
// Operand source: register file value, or the adjusted program counter for register 15
`timescale 1ns/1ps
module cib_operand_sel (
  // Register read
  input wire logic [cib_pkg::REG_W-1:0] regNum,
  input wire logic [cib_pkg::DATA_W-1:0] regData,
  // Current instruction address
  input wire logic [cib_pkg::DATA_W-1:0] instrAddr,
  // Selected operand
  output logic [cib_pkg::DATA_W-1:0] operand
);
  always_comb begin
    if (regNum == cib_pkg::PC_REG) begin
      operand = (instrAddr + cib_pkg::PC_AHEAD) & cib_pkg::BIT0_MASK;
    end else begin
      operand = regData;
    end
  end
endmodule

// ### logic/cib_exec.sv
// Execute unit for hi-register/branch-exchange, pc-relative load and register-offset load/store
// Behaviour
// - op 00 adds source to destination, high-select flags widen each operand.
// - only compare updates flags; add, move and branch-exchange leave them.
// - ops 00/01/10 with both high-selects clear are undefined.
// - op 01 subtracts source from destination, sets flags, discards difference.
// - op 10 copies source into destination for all non low/low pairings.
// - op 11 with destination select clear branches to source register address.
// - target bit 0 picks state: zero 32-bit, one compressed.
// - branch-exchange with destination high-select set is undefined.
// - each instruction takes the cycles of its 32-bit equivalent.
// - reading register 15 yields instruction address plus 4, bit 0 cleared.
// - branch-exchange to pc from non-word-aligned address is unpredictable.
// - pc-relative load adds unsigned word offset to pc, loads word.
// - pc-relative base is instruction address plus 4 with bit 1 cleared.
// - eight-bit immediate counts words, multiplied by four for bytes.
// - register-offset address is base plus offset, both low registers.
// - load/byte 00 stores word; 10 loads word into destination.
// - byte flag set moves one byte; load flag picks store or load.
`timescale 1ns/1ps
module cib_exec (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Instruction issue
  input wire logic instrValid,
  input wire logic [cib_pkg::INSTR_W-1:0] instr,
  input wire logic [cib_pkg::DATA_W-1:0] instrAddr,
  output logic instrReady,
  output logic instrDone,
  output logic undefOp,
  // Register file
  output logic [cib_pkg::REG_W-1:0] rdAddrA,
  output logic [cib_pkg::REG_W-1:0] rdAddrB,
  output logic [cib_pkg::REG_W-1:0] rdAddrC,
  input wire logic [cib_pkg::DATA_W-1:0] rdDataA,
  input wire logic [cib_pkg::DATA_W-1:0] rdDataB,
  input wire logic [cib_pkg::DATA_W-1:0] rdDataC,
  output logic wrEn,
  output logic [cib_pkg::REG_W-1:0] wrAddr,
  output logic [cib_pkg::DATA_W-1:0] wrData,
  // Program status flags
  output logic flagWe,
  output logic [3:0] flagsNzcv,
  // Branch
  output logic branchTaken,
  output logic [cib_pkg::DATA_W-1:0] branchTarget,
  output logic compressedState,
  // Data memory
  output logic memReq,
  output logic memWrite,
  output logic memByte,
  output logic [cib_pkg::DATA_W-1:0] memAddr,
  output logic [cib_pkg::DATA_W-1:0] memWdata,
  input wire logic memAck,
  input wire logic [cib_pkg::DATA_W-1:0] memRdata
);
  cib_pkg::cib_state_e state;
  logic [cib_pkg::INSTR_W-1:0] instrReg;
  logic [cib_pkg::DATA_W-1:0] pcReg;
  logic [cib_pkg::CNT_W-1:0] cntReg;
  logic [cib_pkg::CNT_W-1:0] budgetReg;
  logic [cib_pkg::CNT_W-1:0] budgetNext;
  logic [cib_pkg::INSTR_W-1:0] instrSel;
  logic accept;
  logic execNow;
  logic isHi;
  logic isPcl;
  logic isLdst;
  logic [1:0] hiOp;
  logic dstHigh;
  logic srcHigh;
  logic ldFlag;
  logic byteFlag;
  logic [cib_pkg::REG_W-1:0] hiDst;
  logic [cib_pkg::REG_W-1:0] hiSrc;
  logic [cib_pkg::REG_W-1:0] lowMid;
  logic [cib_pkg::REG_W-1:0] lowLow;
  logic [cib_pkg::REG_W-1:0] lowRo;
  logic [cib_pkg::REG_W-1:0] pclDst;
  logic [cib_pkg::REG_W-1:0] loadDst;
  logic [cib_pkg::DATA_W-1:0] opA;
  logic [cib_pkg::DATA_W-1:0] opB;
  logic [cib_pkg::DATA_W-1:0] opC;
  logic [cib_pkg::DATA_W-1:0] sum;
  logic [cib_pkg::DATA_W:0] diff;
  logic [cib_pkg::DATA_W-1:0] hiResult;
  logic [cib_pkg::DATA_W-1:0] pclAddr;
  logic hiUndef;
  logic dstIsPc;
  logic needMem;

  // Decode from the bus while idle, from the held copy afterwards
  assign instrSel = (state == cib_pkg::ST_IDLE) ? instr : instrReg;
  assign accept = (state == cib_pkg::ST_IDLE) && instrValid && instrReady;
  assign execNow = (state == cib_pkg::ST_READ);

  assign isHi = instrSel[cib_pkg::INSTR_W-1:cib_pkg::F5_SIG_LO] == cib_pkg::F5_SIG;
  assign isPcl = instrSel[cib_pkg::INSTR_W-1:cib_pkg::F6_SIG_LO] == cib_pkg::F6_SIG;
  assign isLdst = (instrSel[cib_pkg::INSTR_W-1:cib_pkg::F7_SIG_LO] == cib_pkg::F7_SIG) && !instrSel[cib_pkg::F7_ZERO];
  assign hiOp = instrSel[cib_pkg::F5_OP_HI:cib_pkg::F5_OP_LO];
  assign dstHigh = instrSel[cib_pkg::F5_DHI];
  assign srcHigh = instrSel[cib_pkg::F5_SHI];
  assign ldFlag = instrSel[cib_pkg::F7_LOAD];
  assign byteFlag = instrSel[cib_pkg::F7_BYTE];
  assign lowMid = {1'b0, instrSel[cib_pkg::F_MID_HI:cib_pkg::F_MID_LO]};
  assign lowLow = {1'b0, instrSel[cib_pkg::F_LOW_HI:cib_pkg::F_LOW_LO]};
  assign lowRo = {1'b0, instrSel[cib_pkg::F7_RO_HI:cib_pkg::F7_RO_LO]};
  assign pclDst = {1'b0, instrSel[cib_pkg::F6_RD_HI:cib_pkg::F6_RD_LO]};
  assign hiDst = {dstHigh, instrSel[cib_pkg::F_LOW_HI:cib_pkg::F_LOW_LO]};
  assign hiSrc = {srcHigh, instrSel[cib_pkg::F_MID_HI:cib_pkg::F_MID_LO]};
  assign loadDst = isPcl ? pclDst : lowLow;

  cib_operand_sel uSelA (
    .regNum(rdAddrA),
    .regData(rdDataA),
    .instrAddr(pcReg),
    .operand(opA)
  );
  cib_operand_sel uSelB (
    .regNum(rdAddrB),
    .regData(rdDataB),
    .instrAddr(pcReg),
    .operand(opB)
  );
  cib_operand_sel uSelC (
    .regNum(rdAddrC),
    .regData(rdDataC),
    .instrAddr(pcReg),
    .operand(opC)
  );

  always_comb begin
    sum = opA + opB;
    diff = {1'b0, opA} - {1'b0, opB};
    hiUndef = isHi && (hiOp == cib_pkg::HI_BX ? dstHigh : (!dstHigh && !srcHigh));
    hiResult = (hiOp == cib_pkg::HI_ADD) ? sum : opB;
    dstIsPc = (hiDst == cib_pkg::PC_REG);
    pclAddr = ((pcReg + cib_pkg::PC_AHEAD) & cib_pkg::BIT1_MASK)
      + (cib_pkg::DATA_W'(instrSel[cib_pkg::F6_IMM_HI:cib_pkg::F6_IMM_LO]) << cib_pkg::WORD_SHIFT);
    needMem = isPcl || isLdst;
    if (isHi && !hiUndef && hiOp == cib_pkg::HI_BX) begin
      budgetNext = cib_pkg::CYC_BX;
    end else if (isHi && !hiUndef && hiOp != cib_pkg::HI_CMP && dstIsPc) begin
      budgetNext = cib_pkg::CYC_PC_WRITE;
    end else if (isPcl || (isLdst && ldFlag)) begin
      budgetNext = cib_pkg::CYC_LOAD;
    end else if (isLdst) begin
      budgetNext = cib_pkg::CYC_STORE;
    end else begin
      budgetNext = cib_pkg::CYC_ALU;
    end
  end

  // Sequencing; budget counts from the first execute cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= cib_pkg::ST_IDLE;
      instrReg <= 16'h0000;
      pcReg <= 32'h00000000;
      cntReg <= 4'h0;
      budgetReg <= 4'h0;
      instrReady <= 1'b1;
      instrDone <= 1'b0;
    end else begin
      instrDone <= 1'b0;
      case (state)
        cib_pkg::ST_IDLE: begin
          if (accept) begin
            instrReg <= instr;
            pcReg <= instrAddr;
            instrReady <= 1'b0;
            state <= cib_pkg::ST_READ;
          end
        end
        cib_pkg::ST_READ: begin
          cntReg <= 4'h1;
          budgetReg <= budgetNext;
          state <= needMem ? cib_pkg::ST_MEM : cib_pkg::ST_HOLD;
        end
        cib_pkg::ST_MEM: begin
          cntReg <= cntReg + 4'h1;
          if (memAck) begin
            state <= cib_pkg::ST_HOLD;
          end
        end
        default: begin
          if (cntReg >= budgetReg) begin
            instrDone <= 1'b1;
            instrReady <= 1'b1;
            state <= cib_pkg::ST_IDLE;
          end else begin
            cntReg <= cntReg + 4'h1;
          end
        end
      endcase
    end
  end

  // Read ports; addresses fixed for the whole instruction
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdAddrA <= 4'h0;
      rdAddrB <= 4'h0;
      rdAddrC <= 4'h0;
    end else if (accept) begin
      if (isHi) begin
        rdAddrA <= hiDst;
        rdAddrB <= hiSrc;
        rdAddrC <= 4'h0;
      end else begin
        rdAddrA <= lowMid;
        rdAddrB <= lowRo;
        rdAddrC <= lowLow;
      end
    end
  end

  // Register write-back
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrEn <= 1'b0;
      wrAddr <= 4'h0;
      wrData <= 32'h00000000;
    end else begin
      wrEn <= 1'b0;
      if (execNow && isHi && !hiUndef && (hiOp == cib_pkg::HI_ADD || hiOp == cib_pkg::HI_MOV) && !dstIsPc) begin
        wrEn <= 1'b1;
        wrAddr <= hiDst;
        wrData <= hiResult;
      end else if (state == cib_pkg::ST_MEM && memAck && !memWrite) begin
        wrEn <= 1'b1;
        wrAddr <= loadDst;
        wrData <= memByte ? {24'h000000, memRdata[7:0]} : memRdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flagWe <= 1'b0;
      flagsNzcv <= 4'h0;
    end else begin
      flagWe <= 1'b0;
      if (execNow && isHi && !hiUndef && hiOp == cib_pkg::HI_CMP) begin
        flagWe <= 1'b1;
        flagsNzcv <= {diff[cib_pkg::DATA_W-1], diff[cib_pkg::DATA_W-1:0] == 32'h00000000, !diff[cib_pkg::DATA_W],
          (opA[cib_pkg::DATA_W-1] ^ opB[cib_pkg::DATA_W-1]) & (opA[cib_pkg::DATA_W-1] ^ diff[cib_pkg::DATA_W-1])};
      end
    end
  end

  // Branches; a misaligned pc target is taken as computed, no guard
  // misaligned left unguarded
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      branchTaken <= 1'b0;
      branchTarget <= 32'h00000000;
      compressedState <= cib_pkg::RESET_COMPRESSED;
      undefOp <= 1'b0;
    end else begin
      branchTaken <= 1'b0;
      undefOp <= execNow && (hiUndef || !(isHi || isPcl || isLdst));
      if (execNow && isHi && !hiUndef) begin
        if (hiOp == cib_pkg::HI_BX) begin
          branchTaken <= 1'b1;
          branchTarget <= opB & cib_pkg::BIT0_MASK;
          compressedState <= opB[cib_pkg::STATE_BIT];
        end else if (hiOp != cib_pkg::HI_CMP && dstIsPc) begin
          branchTaken <= 1'b1;
          branchTarget <= hiResult & cib_pkg::BIT0_MASK;
        end
      end
    end
  end

  // Data memory request held until acknowledged
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memByte <= 1'b0;
      memAddr <= 32'h00000000;
      memWdata <= 32'h00000000;
    end else if (execNow && needMem) begin
      memReq <= 1'b1;
      memWrite <= isLdst && !ldFlag;
      memByte <= isLdst && byteFlag;
      memAddr <= isPcl ? pclAddr : sum;
      memWdata <= (isLdst && byteFlag) ? {24'h000000, opC[7:0]} : opC;
    end else if (state == cib_pkg::ST_MEM && memAck) begin
      memReq <= 1'b0;
    end
  end
endmodule

// ### tb/cib_reg_mem_model.sv
// Register file and data memory model facing the execute block
`timescale 1ns/1ps
module cib_reg_mem_model #(
  parameter logic [31:0] MIX = 32'h5A5AC3C3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register file
  input wire logic [3:0] rdAddrA,
  input wire logic [3:0] rdAddrB,
  input wire logic [3:0] rdAddrC,
  output logic [31:0] rdDataA,
  output logic [31:0] rdDataB,
  output logic [31:0] rdDataC,
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [31:0] wrData,
  // Data memory
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic slowAck,
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [31:0] regs [16];
  logic [1:0] waitCnt;
  logic served;
  assign rdDataA = regs[rdAddrA];
  assign rdDataB = regs[rdAddrB];
  assign rdDataC = regs[rdAddrC];
  // Plain always so the bench can preload regs
  always @(posedge ref_clk) begin
    if (wrEn) begin
      regs[wrAddr] <= wrData;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memAck <= 1'b0;
      served <= 1'b0;
      waitCnt <= 2'h0;
      memRdata <= 32'h00000000;
    end else begin
      memAck <= 1'b0;
      // Idle bus toggles, stale data never looks valid
      memRdata <= ~memRdata;
      if (!memReq) begin
        served <= 1'b0;
      end else if (!served && waitCnt == {slowAck, slowAck}) begin
        memAck <= 1'b1;
        memRdata <= memAddr ^ MIX;
        served <= 1'b1;
        waitCnt <= 2'h0;
      end else if (!served) begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule

// ### tb/cib_exec_checker.sv
// Port assertions for the execute block
`timescale 1ns/1ps
module cib_exec_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire logic instrValid,
  input wire logic [15:0] instr,
  input wire logic instrReady,
  input wire logic instrDone,
  input wire logic undefOp,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  input wire logic flagWe,
  input wire logic branchTaken,
  input wire logic compressedState,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic memByte,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic memAck
);
  logic [15:0] heldInstr;
  logic acc, hiNew, badNew, cmpNew, isCmp, isLdst, isPcl;
  assign acc = instrValid && instrReady;
  assign hiNew = instr[15:10] == cib_pkg::F5_SIG;
  assign badNew = hiNew && (instr[9:8] == cib_pkg::HI_BX ? instr[7] : instr[7:6] == 2'b00);
  assign cmpNew = hiNew && instr[9:8] == cib_pkg::HI_CMP && instr[7:6] != 2'b00;
  assign isCmp = heldInstr[15:10] == cib_pkg::F5_SIG && heldInstr[9:8] == cib_pkg::HI_CMP;
  assign isLdst = heldInstr[15:12] == cib_pkg::F7_SIG && !heldInstr[9];
  assign isPcl = heldInstr[15:11] == cib_pkg::F6_SIG;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      heldInstr <= 16'h0000;
    end else if (acc) begin
      heldInstr <= instr;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_undef_quiet; undefOp |-> !wrEn && !flagWe && !branchTaken && !memReq; endproperty
  a_undef_quiet: assert property (p_undef_quiet) else $error("undefined op gave a result");
  property p_undef_flag; acc && badNew |-> ##2 undefOp; endproperty
  a_undef_flag: assert property (p_undef_flag) else $error("undefined op not flagged");
  property p_cmp_only; flagWe |-> isCmp; endproperty
  a_cmp_only: assert property (p_cmp_only) else $error("flags written by non compare");
  property p_cmp_time; acc && cmpNew |-> ##2 flagWe ##1 instrDone; endproperty
  a_cmp_time: assert property (p_cmp_time) else $error("compare timing wrong");
  property p_state_hold; !branchTaken && !$past(branchTaken) |-> $stable(compressedState); endproperty
  a_state_hold: assert property (p_state_hold) else $error("state changed without branch");
  property p_byte_store; memReq && memWrite && memByte |-> memWdata[31:8] == 24'h000000; endproperty
  a_byte_store: assert property (p_byte_store) else $error("byte store upper bits set");
  property p_ldst_kind; memReq && isLdst |-> memWrite == !heldInstr[11] && memByte == heldInstr[10]; endproperty
  a_ldst_kind: assert property (p_ldst_kind) else $error("load store kind wrong");
  property p_pcl_kind; memReq && isPcl |-> !memWrite && !memByte && memAddr[1:0] == 2'b00; endproperty
  a_pcl_kind: assert property (p_pcl_kind) else $error("pc load access wrong");
  property p_byte_load; wrEn && isLdst && heldInstr[10] |-> wrData[31:8] == 24'h000000; endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load upper bits set");
  property p_req_hold; memReq && !memAck |=> memReq && $stable(memAddr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request dropped early");
endmodule
bind cib_exec cib_exec_checker u_chk (.ref_clk, .rst, .instrValid, .instr, .instrReady, .instrDone, .undefOp,
  .wrEn, .wrData, .flagWe, .branchTaken, .compressedState, .memReq, .memWrite, .memByte, .memAddr,
  .memWdata, .memAck);

// ### tb/tb_top.sv
// Self-checking bench for the execute block
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] MIX = 32'h5A5AC3C3;
  logic ref_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, slowAck = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [31:0] instrAddr = 32'h00000000, pcNow;
  logic instrReady, instrDone, undefOp, wrEn, flagWe, branchTaken, compressedState;
  logic memReq, memWrite, memByte, memAck;
  logic [3:0] rdAddrA, rdAddrB, rdAddrC, wrAddr, flagsNzcv;
  logic [31:0] rdDataA, rdDataB, rdDataC, wrData, branchTarget, memAddr, memWdata, memRdata;
  int errors = 0, n_compared = 0;
  logic [39:0] notes [$];
  logic [31:0] sh [16];
  always #2.5 ref_clk = ~ref_clk;
  cib_exec u_dut (.ref_clk, .rst, .instrValid, .instr, .instrAddr, .instrReady, .instrDone, .undefOp,
    .rdAddrA, .rdAddrB, .rdAddrC, .rdDataA, .rdDataB, .rdDataC, .wrEn, .wrAddr, .wrData, .flagWe,
    .flagsNzcv, .branchTaken, .branchTarget, .compressedState, .memReq, .memWrite, .memByte,
    .memAddr, .memWdata, .memAck, .memRdata);
  cib_reg_mem_model #(.MIX(MIX)) u_mod (.ref_clk, .rst, .rdAddrA, .rdAddrB, .rdAddrC, .rdDataA,
    .rdDataB, .rdDataC, .wrEn, .wrAddr, .wrData, .memReq, .memAddr, .slowAck, .memAck, .memRdata);
  task give_verdict;
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [39:0] seen, input string nm);
    logic [39:0] exp;
    n_compared++;
    exp = (notes.size() > 0) ? notes.pop_front() : 40'hX;
    if (exp !== seen) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Result watcher against oldest note
  always @(posedge ref_clk) begin
    if (!rst) begin
      if (memReq && memAck) chk({4'h4, 2'b00, memWrite, memByte, memAddr}, "memAddr");
      if (memReq && memAck && memWrite) chk({8'h50, memWdata}, "memWdata");
      if (wrEn) chk({4'h1, wrAddr, wrData}, "wrData");
      if (flagWe) chk({8'h20, 28'h0, flagsNzcv}, "flags");
      if (branchTaken) chk({7'h30, compressedState, branchTarget}, "branch");
      if (undefOp) chk({4'h6, 36'h0}, "undefOp");
    end
  end
  // Register 15 reads as address plus 4, bit 0 clear
  function logic [31:0] rv(input logic [3:0] r);
    rv = (r == 4'hF) ? ((pcNow + 32'h4) & 32'hFFFFFFFE) : sh[r];
  endfunction
  function logic [15:0] hi(input logic [1:0] op, input logic [3:0] d, input logic [3:0] s);
    hi = {6'h11, op, d[3], s[3], s[2:0], d[2:0]};
  endfunction
  task run(input logic [15:0] w, input int budget);
    int n;
    @(posedge ref_clk);
    while (instrReady !== 1'b1) @(posedge ref_clk);
    instrValid <= 1'b1;
    instr <= w;
    instrAddr <= pcNow;
    @(posedge ref_clk);
    instrValid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (instrDone !== 1'b1 && n < 40);
    n_compared++;
    if (n >= 40 || (budget > 0 && n != budget + 1)) begin
      errors++;
      $display("Error cycles expected %0d seen %0d", budget + 1, n);
    end
  endtask
  initial begin
    #100000;
    errors++;
    give_verdict;
  end
  initial begin
    logic [3:0] d, s;
    logic [31:0] a, b, df, ea, v;
    logic [7:0] imm;
    void'($urandom(32'hA8B0));
    for (int i = 0; i < 16; i++) begin
      sh[i] = $urandom();
      u_mod.regs[i] = sh[i];
    end
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    // Add, compare, move over every legal pairing
    for (int k = 0; k < 18; k++) begin
      d = {k[0] | !k[1], 3'($urandom_range(6, 0))};
      if (k == 17) d = 4'hF;
      s = {k[1], 3'($urandom())};
      pcNow = $urandom() & 32'hFFFFFFFE;
      a = rv(d);
      b = rv(s);
      df = a - b;
      if (k % 3 == 1) notes.push_back({8'h20, 28'h0, df[31], df == 0, a >= b, (a[31] != b[31]) && (df[31] != a[31])});
      else if (d == 4'hF) notes.push_back({7'h30, 1'b1, b & 32'hFFFFFFFE});
      else begin
        sh[d] = (k % 3 == 0) ? a + b : b;
        notes.push_back({4'h1, d, sh[d]});
      end
      run(hi(2'(k % 3), d, s), (d == 4'hF) ? 3 : 1);
    end
    // Undefined encodings refused
    for (int k = 0; k < 5; k++) begin
      notes.push_back({4'h6, 36'h0});
      run((k == 4) ? 16'h0000 : hi(2'(k), (k == 3) ? 4'h8 : 4'h2, (k == 3) ? 4'h1 : 4'h3), 1);
    end
    // Branch-exchange, both target states
    for (int k = 0; k < 4; k++) begin
      s = (k == 3) ? 4'hF : 4'(k * 4 + 1);
      sh[s][0] = k[0];
      u_mod.regs[s] = sh[s];
      pcNow = $urandom() & 32'hFFFFFFFC;
      v = rv(s);
      notes.push_back({7'h30, v[0], v & 32'hFFFFFFFE});
      run(hi(2'h3, 4'h0, s), 3);
    end
    // Pc-relative word load, offset extremes
    for (int k = 0; k < 3; k++) begin
      imm = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom());
      d = 4'($urandom_range(7, 0));
      pcNow = ($urandom() & 32'hFFFFFFFC) | 32'h2;
      ea = ((pcNow + 32'h4) & 32'hFFFFFFFD) + {22'h0, imm, 2'b00};
      sh[d] = ea ^ MIX;
      notes.push_back({8'h40, ea});
      notes.push_back({4'h1, d, sh[d]});
      run({5'h09, d[2:0], imm}, 0);
    end
    // Register-offset word and byte, fast and slow memory
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      slowAck <= k[2];
      a = $urandom();
      b = $urandom();
      d = 4'($urandom_range(7, 0));
      ea = sh[a[2:0]] + sh[b[2:0]];
      notes.push_back({6'h10, !k[1], k[0], ea});
      v = k[1] ? ea ^ MIX : sh[d];
      if (k[0]) v = {24'h0, v[7:0]};
      if (k[1]) sh[d] = v;
      notes.push_back(k[1] ? {4'h1, d, v} : {8'h50, v});
      run({4'h5, k[1], k[0], 1'b0, b[2:0], a[2:0], d[2:0]}, 0);
    end
    repeat (5) @(posedge ref_clk);
    n_compared++;
    if (notes.size() != 0) begin
      errors++;
      $display("Error notes expected 0 seen %0d", notes.size());
    end
    give_verdict;
  end
endmodule
